// ### src/cwd_pkg.sv
/*
 package of the converter window detector: register addresses, reset values
 and field positions. assumes an 8-bit special-function register port.
*/
package cwd_pkg;
   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] CWD_ADDR_UPPER_LO = 8'hc3;
   localparam logic [7:0] CWD_ADDR_UPPER_HI = 8'hc4;
   localparam logic [7:0] CWD_ADDR_LOWER_LO = 8'hc5;
   localparam logic [7:0] CWD_ADDR_LOWER_HI = 8'hc6;
   localparam logic [7:0] CWD_ADDR_CTRL     = 8'he8;
   // ---------------------------------------------------------------
   // reset values and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] CWD_UPPER_RESET   = 8'hff;
   localparam logic [7:0] CWD_LOWER_RESET   = 8'h00;
   localparam logic [7:0] CWD_CTRL_RESET    = 8'h00;
   localparam int         CWD_FLAG_BIT      = 3;
   localparam logic [7:0] CWD_READ_UNMAPPED = 8'h00;
endpackage

// ### src/cwd_compare.sv
/*
 window comparison of one converter result against the two limits.
 assumes limits and result are stable inputs on the same clock.
*/
`timescale 1ns/1ps
module cwd_compare (
   // limits and sample
   input  wire logic [15:0] upper_limit,
   input  wire logic [15:0] lower_limit,
   input  wire logic [15:0] sample,
   // result
   output logic             hit
);
   import cwd_pkg::*;

   wire logic above_upper;
   wire logic below_lower;
   wire logic inside_mode;

   assign above_upper = sample > upper_limit;
   assign below_lower = sample < lower_limit;
   // ordering of the limits picks inside or outside detection
   assign inside_mode = lower_limit > upper_limit;
   assign hit = inside_mode ? (above_upper && below_lower)
                            : (above_upper || below_lower);
endmodule

// ### src/cwd_top.sv
/*
 converter window detector: limit registers on the special-function port,
 a window flag in the converter control register set by each new result that hits the window.
 assumes the converter pulses result_valid once per finished conversion.
*/
`timescale 1ns/1ps
module cwd_top (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // special-function register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // converter result
   input  wire logic [15:0] result,
   input  wire logic        result_valid,
   // flag out
   output logic             window_match_flag
);
   import cwd_pkg::*;

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [7:0] upper_hi_q;
   logic [7:0] upper_lo_q;
   logic [7:0] lower_hi_q;
   logic [7:0] lower_lo_q;
   logic [7:0] ctrl_q;
   logic [7:0] rdata_d;
   logic       flag_d;
   logic       hit;
   logic [15:0] upper_limit;
   logic [15:0] lower_limit;

   wire logic wr_upper_hi;
   wire logic wr_upper_lo;
   wire logic wr_lower_hi;
   wire logic wr_lower_lo;
   wire logic wr_ctrl;
   wire logic hit_event;
   wire logic wr_any;

   assign wr_upper_hi = sfr_wr && sfr_addr == CWD_ADDR_UPPER_HI;
   assign wr_upper_lo = sfr_wr && sfr_addr == CWD_ADDR_UPPER_LO;
   assign wr_lower_hi = sfr_wr && sfr_addr == CWD_ADDR_LOWER_HI;
   assign wr_lower_lo = sfr_wr && sfr_addr == CWD_ADDR_LOWER_LO;
   assign wr_ctrl     = sfr_wr && sfr_addr == CWD_ADDR_CTRL;
   // any mapped write; a write anywhere else must leave the limits alone
   assign wr_any      = wr_upper_hi || wr_upper_lo || wr_lower_hi ||
                        wr_lower_lo || wr_ctrl;
   assign upper_limit = {upper_hi_q, upper_lo_q};
   assign lower_limit = {lower_hi_q, lower_lo_q};

   // ---------------------------------------------------------------
   // comparison
   // ---------------------------------------------------------------
   cwd_compare u_cmp (
      .upper_limit (upper_limit),
      .lower_limit (lower_limit),
      .sample      (result),
      .hit         (hit)
   );
   // every result is checked as it arrives
   assign hit_event = result_valid && hit;

   // set wins over a clear written in the same cycle
   always_comb begin
      flag_d = ctrl_q[CWD_FLAG_BIT];
      if (wr_ctrl && !sfr_wdata[CWD_FLAG_BIT]) begin
         flag_d = 1'b0;
      end
      if (hit_event) begin
         flag_d = 1'b1;
      end
   end

   always_comb begin
      unique case (sfr_addr)
         CWD_ADDR_UPPER_HI: rdata_d = upper_hi_q;
         CWD_ADDR_UPPER_LO: rdata_d = upper_lo_q;
         CWD_ADDR_LOWER_HI: rdata_d = lower_hi_q;
         CWD_ADDR_LOWER_LO: rdata_d = lower_lo_q;
         CWD_ADDR_CTRL:     rdata_d = ctrl_q;
         default:           rdata_d = CWD_READ_UNMAPPED;
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         upper_hi_q <= CWD_UPPER_RESET;
         upper_lo_q <= CWD_UPPER_RESET;
         lower_hi_q <= CWD_LOWER_RESET;
         lower_lo_q <= CWD_LOWER_RESET;
      end else begin
         if (wr_upper_hi) upper_hi_q <= sfr_wdata;
         if (wr_upper_lo) upper_lo_q <= sfr_wdata;
         if (wr_lower_hi) lower_hi_q <= sfr_wdata;
         if (wr_lower_lo) lower_lo_q <= sfr_wdata;
      end
   end

   // other control bits are plain storage for the converter
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q <= CWD_CTRL_RESET;
      end else begin
         if (wr_ctrl) ctrl_q <= sfr_wdata;
         ctrl_q[CWD_FLAG_BIT] <= flag_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sfr_rdata         <= CWD_READ_UNMAPPED;
         window_match_flag <= 1'b0;
      end else begin
         sfr_rdata         <= sfr_rd ? rdata_d : CWD_READ_UNMAPPED;
         window_match_flag <= flag_d;
      end
   end

   // ---------------------------------------------------------------
   // checks: window flag
   // ---------------------------------------------------------------
   // the flag is the only state a result may touch, so it is guarded
   // from both sides: set on a hit, held otherwise, cleared by a write
   hit_sets_flag_a: assert property (@(posedge mclk) disable iff (rst)
      hit_event |=> ctrl_q[CWD_FLAG_BIT] && window_match_flag)
      else $error("window hit did not set flag");
   flag_sticks_a: assert property (@(posedge mclk) disable iff (rst)
      ctrl_q[CWD_FLAG_BIT] && !hit_event &&
      !(wr_ctrl && !sfr_wdata[CWD_FLAG_BIT]) |=> ctrl_q[CWD_FLAG_BIT])
      else $error("flag dropped without a clear");
   flag_clear_a: assert property (@(posedge mclk) disable iff (rst)
      wr_ctrl && !sfr_wdata[CWD_FLAG_BIT] && !hit_event
      |=> !ctrl_q[CWD_FLAG_BIT])
      else $error("flag clear ignored");
   no_hit_no_set_a: assert property (@(posedge mclk) disable iff (rst)
      !ctrl_q[CWD_FLAG_BIT] && !hit_event && !wr_ctrl
      |=> !ctrl_q[CWD_FLAG_BIT])
      else $error("flag set without a hit");

   // ---------------------------------------------------------------
   // checks: window decision
   // ---------------------------------------------------------------
   // a result equal to a limit never counts, in either mode
   outside_hit_a: assert property (@(posedge mclk) disable iff (rst)
      result_valid && lower_limit <= upper_limit &&
      (result > upper_limit || result < lower_limit)
      |=> window_match_flag)
      else $error("outside window result not flagged");
   outside_miss_a: assert property (@(posedge mclk) disable iff (rst)
      result_valid && lower_limit <= upper_limit &&
      result <= upper_limit && result >= lower_limit &&
      !ctrl_q[CWD_FLAG_BIT] && !wr_ctrl |=> !window_match_flag)
      else $error("result inside window flagged");
   inside_hit_a: assert property (@(posedge mclk) disable iff (rst)
      result_valid && lower_limit > upper_limit &&
      result > upper_limit && result < lower_limit |=> window_match_flag)
      else $error("inside window result not flagged");
   inside_miss_a: assert property (@(posedge mclk) disable iff (rst)
      result_valid && lower_limit > upper_limit &&
      (result <= upper_limit || result >= lower_limit) &&
      !ctrl_q[CWD_FLAG_BIT] && !wr_ctrl |=> !window_match_flag)
      else $error("result outside window flagged");
   valid_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !result_valid && !ctrl_q[CWD_FLAG_BIT] && !wr_ctrl
      |=> !window_match_flag)
      else $error("flag set with no new result");

   // ---------------------------------------------------------------
   // checks: limit and control registers
   // ---------------------------------------------------------------
   upper_hi_rst_a: assert property (@(posedge mclk)
      rst |=> upper_hi_q == CWD_UPPER_RESET)
      else $error("upper high byte reset wrong");
   upper_lo_rst_a: assert property (@(posedge mclk)
      rst |=> upper_lo_q == CWD_UPPER_RESET)
      else $error("upper low byte reset wrong");
   lower_rst_a: assert property (@(posedge mclk)
      rst |=> lower_hi_q == CWD_LOWER_RESET && lower_lo_q == CWD_LOWER_RESET)
      else $error("lower limit reset wrong");
   ctrl_rst_a: assert property (@(posedge mclk)
      rst |=> ctrl_q == CWD_CTRL_RESET && !window_match_flag)
      else $error("control register reset wrong");
   upper_hi_wr_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == CWD_ADDR_UPPER_HI
      |=> upper_hi_q == $past(sfr_wdata))
      else $error("upper high byte write lost");
   upper_lo_wr_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == CWD_ADDR_UPPER_LO
      |=> upper_lo_q == $past(sfr_wdata))
      else $error("upper low byte write lost");
   lower_hi_wr_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == CWD_ADDR_LOWER_HI
      |=> lower_hi_q == $past(sfr_wdata))
      else $error("lower high byte write lost");
   lower_lo_wr_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == CWD_ADDR_LOWER_LO
      |=> lower_lo_q == $past(sfr_wdata))
      else $error("lower low byte write lost");
   unmapped_wr_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_wr && !wr_any |=> $stable(upper_limit) && $stable(lower_limit))
      else $error("write to a free address changed a limit");

   // ---------------------------------------------------------------
   // checks: read port
   // ---------------------------------------------------------------
   upper_hi_read_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_rd && sfr_addr == CWD_ADDR_UPPER_HI
      |=> sfr_rdata == $past(upper_hi_q))
      else $error("upper high byte readback wrong");
   upper_lo_read_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_rd && sfr_addr == CWD_ADDR_UPPER_LO
      |=> sfr_rdata == $past(upper_lo_q))
      else $error("upper low byte readback wrong");
   lower_hi_read_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_rd && sfr_addr == CWD_ADDR_LOWER_HI
      |=> sfr_rdata == $past(lower_hi_q))
      else $error("lower high byte readback wrong");
   lower_lo_read_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_rd && sfr_addr == CWD_ADDR_LOWER_LO
      |=> sfr_rdata == $past(lower_lo_q))
      else $error("lower low byte readback wrong");
   ctrl_read_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_rd && sfr_addr == CWD_ADDR_CTRL
      |=> sfr_rdata == $past(ctrl_q))
      else $error("control register readback wrong");
   rdata_idle_a: assert property (@(posedge mclk) disable iff (rst)
      !sfr_rd |=> sfr_rdata == CWD_READ_UNMAPPED)
      else $error("read data not cleared between reads");
   rdata_rst_a: assert property (@(posedge mclk)
      rst |=> sfr_rdata == CWD_READ_UNMAPPED)
      else $error("read data reset wrong");
endmodule

// ### testbench/cwd_conv_model.sv
/*
 converter result source for the window detector bench.
 assumes the bench calls convert from its falling-edge driver.
*/
`timescale 1ns/1ps
module cwd_conv_model (
   // clock
   input  wire logic        mclk,
   // converter result
   output logic      [15:0] result,
   output logic             result_valid
);
   initial begin
      result = 16'h0000;
      result_valid = 1'b0;
   end
   // outside the pulse the word is inverted so a stale value never counts
   task automatic convert(logic [15:0] v);
      @(negedge mclk);
      result = v;
      result_valid = 1'b1;
      @(negedge mclk);
      result_valid = 1'b0;
      result = ~v;
   endtask
endmodule

// ### testbench/cwd_tb_top.sv
/*
 self-checking bench of the window detector: limits, flag, register port.
 assumes the converter model of cwd_conv_model.sv.
*/
`timescale 1ns/1ps
module cwd_tb_top;
   import cwd_pkg::*;
   logic mclk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, a, d;
   logic [15:0] result;
   logic result_valid, window_match_flag;
   logic [31:0] seed = 32'h5164;
   int n_errors = 0, n_compared = 0, up, lo, flag, i;
   always #4 mclk = ~mclk;
   cwd_conv_model u_conv (.mclk(mclk), .result(result),
      .result_valid(result_valid));
   cwd_top u_dut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .result(result),
      .result_valid(result_valid), .window_match_flag(window_match_flag));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cmp(logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR sfr_rdata exp %h got %h", e, g);
      end
   endtask
   task automatic cmp_flag(logic e, logic g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR window_match_flag exp %b got %b", e, g);
      end
   endtask
   task automatic wr(logic [7:0] ad, logic [7:0] dt);
      @(negedge mclk);
      sfr_addr = ad;
      sfr_wdata = dt;
      sfr_wr = 1;
      @(negedge mclk);
      sfr_wr = 0;
      case (ad)
         CWD_ADDR_UPPER_LO: up[7:0] = dt;
         CWD_ADDR_UPPER_HI: up[15:8] = dt;
         CWD_ADDR_LOWER_LO: lo[7:0] = dt;
         CWD_ADDR_LOWER_HI: lo[15:8] = dt;
         CWD_ADDR_CTRL: if (!dt[CWD_FLAG_BIT]) flag = 0;
         default: ;
      endcase
   endtask
   task automatic rd(logic [7:0] ad, logic [7:0] e);
      @(negedge mclk);
      sfr_addr = ad;
      sfr_rd = 1;
      @(negedge mclk);
      sfr_rd = 0;
      cmp(e, sfr_rdata);
   endtask
   // strict limits: a word equal to a limit never hits
   task automatic conv(int v);
      if (lo <= up ? (v > up || v < lo) : (v > up && v < lo))
         flag = 1;
      u_conv.convert(v[15:0]);
      cmp_flag(flag[0], window_match_flag);
   endtask
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #(8 * 20000);
      n_errors++;
      final_report();
   end
   initial begin
      up = 32'hffff;
      lo = 0;
      flag = 0;
      repeat (8) @(negedge mclk);
      rst = 0;
      rd(CWD_ADDR_UPPER_LO, CWD_UPPER_RESET);
      rd(CWD_ADDR_UPPER_HI, CWD_UPPER_RESET);
      wr(8'h00, 8'h5a);
      rd(8'h00, CWD_READ_UNMAPPED);
      $display("reset test done");
      for (i = 0; i < 200; i++) begin
         a = CWD_ADDR_UPPER_LO + 8'(rnd() % 4);
         d = 8'(rnd());
         wr(a, d);
         rd(a, d);
         conv(int'(rnd() & 32'hffff));
         conv(up);
         conv(lo);
         rd(CWD_ADDR_CTRL, 8'(flag[0]) << CWD_FLAG_BIT);
         if (i % 4 == 0)
            wr(CWD_ADDR_CTRL, 8'h00);
      end
      // a hit and a clear taken at one edge: the hit wins
      wr(CWD_ADDR_UPPER_HI, 8'h00);
      wr(CWD_ADDR_UPPER_LO, 8'h00);
      wr(CWD_ADDR_LOWER_HI, 8'h00);
      wr(CWD_ADDR_LOWER_LO, 8'h00);
      fork
         wr(CWD_ADDR_CTRL, 8'h00);
         u_conv.convert(16'h0001);
      join
      flag = 1;
      cmp_flag(1'b1, window_match_flag);
      rd(CWD_ADDR_CTRL, 8'(flag[0]) << CWD_FLAG_BIT);
      $display("window test done");
      final_report();
   end
endmodule
